// *** logic/tbm_pkg.sv ***
// Purpose: Shared constants and types for thermistor bias and monitor mux control
// Assumes: AXI4-Lite slave with 32-bit data and 200 MHz sys_clk
// Notes: Register offsets are byte addresses, one aligned word each
// Functional notes
// RULE1 - Four independent 2-bit trip selects: hot, warm, cool, cold.
// RULE2 - With monitor enabled, node is compared continuously against trip levels.
// RULE3 - Bias on when charge supply valid and thermistor monitor enabled.
// RULE4 - Bias also on when mux routes sense node or bias node out.
// RULE5 - Mux selection never disturbs comparators or automatic temperature response.
// RULE6 - A 4-bit channel select picks the signal for the monitor pin.
// RULE7 - Output buffer enabled only while channel select is nonzero.
// RULE8 - Monitor pin is high impedance while channel select is zero.
// RULE9 - Host should write zero select when not converting, saving buffer current.
// RULE10 - Battery current channels selectable any time, in any charger mode.
// RULE11 - Host selects discharge null channel first and stores its conversion.
// RULE12 - Host waits channel switching time after each select write.
// RULE13 - Host then selects discharge channel, converts, computes against null.
// RULE14 - Host selects charge channel, waits switching time, converts; no null.
// RULE15 - 4-bit discharge full-scale setting, default is the 300 mA scale.
// RULE16 - Charge monitor full scale follows the 6-bit fast-charge setting.
// RULE17 - Channel select holds until rewritten and applies with no other command.
`default_nettype none
package tbm_pkg;
  // Register byte offsets
  localparam logic [3:0] TBM_TRIP_OFF = 4'h0;
  localparam logic [3:0] TBM_CTRL_OFF = 4'h4;
  localparam logic [3:0] TBM_MUX_OFF = 4'h8;
  localparam logic [3:0] TBM_STAT_OFF = 4'hC;
  // Field positions in trip register
  localparam int TBM_HOT_POS = 0;
  localparam int TBM_WARM_POS = 2;
  localparam int TBM_COOL_POS = 4;
  localparam int TBM_COLD_POS = 6;
  // Field positions in mux register
  localparam int TBM_SEL_POS = 0;
  localparam int TBM_DSCALE_POS = 4;
  localparam int TBM_CC_POS = 8;
  // Reset values
  localparam logic [7:0] TBM_TRIP_RST = 8'h00;
  localparam logic TBM_THM_ON_RST = 1'b0;
  localparam logic [3:0] TBM_SEL_RST = 4'h0;
  localparam logic [3:0] TBM_DSCALE_RST = 4'h0; // Code for the 300 mA scale
  localparam logic [5:0] TBM_CC_RST = 6'h00;
  // Channel codes with documented meaning
  localparam logic [3:0] TBM_CH_OFF = 4'h0;
  localparam logic [3:0] TBM_CH_CHG = 4'h4;
  localparam logic [3:0] TBM_CH_DISCHG = 4'h5;
  localparam logic [3:0] TBM_CH_NULL = 4'h6;
  // Thermistor node channel codes, not fixed by the text
  localparam logic [3:0] TBM_CH_THM = 4'h8;
  localparam logic [3:0] TBM_CH_THERM_BIAS_NODE = 4'h9;
  // Channel switching time and derived cycle count
  localparam int TBM_CLK_MHZ = 200;
  localparam int TBM_SW_TIME_NS = 300;
  localparam int TBM_SW_CYC = (TBM_SW_TIME_NS * TBM_CLK_MHZ + 999) / 1000;
  // Comparator results from the analog front end
  typedef struct packed {
    logic above_hot;
    logic above_warm;
    logic below_cool;
    logic below_cold;
  } tbm_cmp_t;
  // Temperature zone summary
  typedef enum logic [4:0] {
    TBM_Z_OFF = 5'h01,
    TBM_Z_NORMAL = 5'h02,
    TBM_Z_JEITA = 5'h04,
    TBM_Z_FAULT = 5'h08,
    TBM_Z_SPARE = 5'h10
  } tbm_zone_t;
endpackage
`default_nettype wire

// *** logic/tbm_zone.sv ***
// Purpose: Classify battery temperature from comparator results
// Assumes: Comparator flags are synchronous to sys_clk
// Notes: Runs whatever the monitor mux selects
`default_nettype none
module tbm_zone
  import tbm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic therm_monitor_on,
  input wire tbm_cmp_t cmp,
  output var tbm_zone_t zone
);
  // Zone register; no mux input reaches here at all
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      zone <= TBM_Z_OFF;
    else if (!therm_monitor_on)
      zone <= TBM_Z_OFF;
    else if (cmp.above_hot || cmp.below_cold) // RULE2
      zone <= TBM_Z_FAULT;
    else if (cmp.above_warm || cmp.below_cool) // RULE2
      zone <= TBM_Z_JEITA;
    else
      zone <= TBM_Z_NORMAL; // RULE5
  end
endmodule
`default_nettype wire

// *** logic/tbm_top.sv ***
// Purpose: Thermistor bias and monitor multiplexer control with AXI4-Lite registers
// Assumes: One clock, analog comparators and mux outside this logic
// Notes: Monitor pin drive reduced to buffer enable and channel code
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`default_nettype none
module tbm_top
  import tbm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic charge_input_supply,
  input wire tbm_cmp_t cmp,
  output logic therm_bias_on,
  output logic monitor_buffer_on,
  output logic [3:0] mux_channel,
  output logic [1:0] hot_trip_level,
  output logic [1:0] warm_trip_level,
  output logic [1:0] cool_trip_level,
  output logic [1:0] cold_trip_level,
  output logic [3:0] discharge_monitor_fullscale,
  output logic [5:0] fast_charge_current_setting,
  output logic switch_settled,
  output var tbm_zone_t zone
);
  logic therm_monitor_on;
  logic [3:0] monitor_channel_select;
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [1:0] next_bresp;
  logic [7:0] settle_cnt;
  logic sel_written;

  // Write address and data captured in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // Unmapped or read-only targets answer SLVERR
  always_comb
  begin
    case (aw_addr)
      TBM_TRIP_OFF, TBM_CTRL_OFF, TBM_MUX_OFF: next_bresp = 2'h0;
      default: next_bresp = 2'h2;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_bresp;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Trip level selects, one byte lane
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      {cold_trip_level, cool_trip_level, warm_trip_level, hot_trip_level} <= TBM_TRIP_RST;
    else if (do_write && aw_addr == TBM_TRIP_OFF && w_strb[0])
    begin
      hot_trip_level <= w_data[TBM_HOT_POS +: 2]; // RULE1
      warm_trip_level <= w_data[TBM_WARM_POS +: 2]; // RULE1
      cool_trip_level <= w_data[TBM_COOL_POS +: 2]; // RULE1
      cold_trip_level <= w_data[TBM_COLD_POS +: 2]; // RULE1
    end
  end

  // Thermistor monitor enable
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      therm_monitor_on <= TBM_THM_ON_RST;
    else if (do_write && aw_addr == TBM_CTRL_OFF && w_strb[0])
      therm_monitor_on <= w_data[0];
  end

  // Mux select and scales; no charger state gates the select
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      monitor_channel_select <= TBM_SEL_RST;
      discharge_monitor_fullscale <= TBM_DSCALE_RST;
      fast_charge_current_setting <= TBM_CC_RST;
    end
    else if (do_write && aw_addr == TBM_MUX_OFF)
    begin
      if (w_strb[0])
      begin
        monitor_channel_select <= w_data[TBM_SEL_POS +: 4]; // RULE17 RULE10
        discharge_monitor_fullscale <= w_data[TBM_DSCALE_POS +: 4]; // RULE15
      end
      if (w_strb[1])
        fast_charge_current_setting <= w_data[TBM_CC_POS +: 6]; // RULE16
    end
  end

  assign sel_written = do_write && aw_addr == TBM_MUX_OFF && w_strb[0];

  // Settle counter reports when the switching time has passed
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      settle_cnt <= 8'h00;
    else if (sel_written)
      settle_cnt <= 8'(TBM_SW_CYC); // RULE12
    else if (settle_cnt != 8'h00)
      settle_cnt <= settle_cnt - 8'h01;
  end
  assign switch_settled = (settle_cnt == 8'h00);

  // Bias from supply, enable and held select; buffer and channel straight from the held select
  assign therm_bias_on = (charge_input_supply && therm_monitor_on) // RULE3
    || monitor_channel_select == TBM_CH_THM // RULE4
    || monitor_channel_select == TBM_CH_THERM_BIAS_NODE; // RULE4
  assign monitor_buffer_on = (monitor_channel_select != TBM_CH_OFF); // RULE7 RULE8
  assign mux_channel = monitor_channel_select; // RULE6

  // Temperature classification, independent of the mux
  tbm_zone u_zone
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .therm_monitor_on(therm_monitor_on),
    .cmp(cmp),
    .zone(zone)
  );

  // Read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        TBM_TRIP_OFF: s_axi_rdata <= {24'h000000, cold_trip_level, cool_trip_level,
          warm_trip_level, hot_trip_level};
        TBM_CTRL_OFF: s_axi_rdata <= {31'h0, therm_monitor_on};
        TBM_MUX_OFF: s_axi_rdata <= {18'h0, fast_charge_current_setting,
          discharge_monitor_fullscale, monitor_channel_select};
        TBM_STAT_OFF: s_axi_rdata <= {23'h0, switch_settled, therm_bias_on,
          monitor_buffer_on, 1'b0, zone};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks on the control outputs
  localparam int SW_CYC_I = TBM_SW_CYC;

  // Cycles since the last select write, saturating; rewrites restart the settle span
  logic [7:0] settle_ref;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      settle_ref <= 8'hFF;
    else if (sel_written)
      settle_ref <= 8'h01;
    else if (settle_ref != 8'hFF)
      settle_ref <= settle_ref + 8'h01;
  end

  // Write strobes for the register checks; w_data stands until the response is taken
  logic trip_written;
  logic cc_written;
  assign trip_written = do_write && aw_addr == TBM_TRIP_OFF && w_strb[0];
  assign cc_written = do_write && aw_addr == TBM_MUX_OFF && w_strb[1];

  // Buffer follows the select
  a_buffer_off_zero: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE8
    (monitor_channel_select == TBM_CH_OFF) |-> !monitor_buffer_on)
    else $error("buffer on with zero select");
  a_buffer_on_sel: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE7
    (mux_channel != TBM_CH_OFF) |-> monitor_buffer_on)
    else $error("buffer off with channel selected");

  // Bias source causes
  a_bias_supply: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE3
    (charge_input_supply && therm_monitor_on) |-> therm_bias_on)
    else $error("bias off with supply and monitor on");
  a_bias_node_sel: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE4
    (mux_channel == TBM_CH_THM || mux_channel == TBM_CH_THERM_BIAS_NODE) |-> therm_bias_on)
    else $error("bias off with node routed");
  a_bias_idle_off: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE4
    (!charge_input_supply && mux_channel == TBM_CH_OFF) |-> !therm_bias_on)
    else $error("bias on without cause");

  // Select register and switching time
  a_sel_applied: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE17
    sel_written |=> (mux_channel == $past(w_data[3:0])))
    else $error("select not applied");
  a_sel_held: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE17
    !sel_written |=> $stable(mux_channel))
    else $error("select changed without write");
  a_settle_low: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE12
    sel_written |=> !switch_settled [*8])
    else $error("settled too soon after select write");
  a_settle_time: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE12
    switch_settled == (settle_ref > SW_CYC_I))
    else $error("switching time wrong");

  // Trip levels and monitor scales
  a_trip_applied: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE1
    trip_written |=>
      ({cold_trip_level, cool_trip_level, warm_trip_level, hot_trip_level} == w_data[7:0]))
    else $error("trip levels not applied");
  a_trip_held: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE1
    !trip_written |=>
      $stable({cold_trip_level, cool_trip_level, warm_trip_level, hot_trip_level}))
    else $error("trip levels changed without write");
  a_scale_applied: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE15
    sel_written |=> (discharge_monitor_fullscale == w_data[TBM_DSCALE_POS +: 4]))
    else $error("discharge scale not applied");
  a_scale_held: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE15
    !sel_written |=> $stable(discharge_monitor_fullscale))
    else $error("discharge scale changed without write");
  a_cc_applied: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE16
    cc_written |=> (fast_charge_current_setting == w_data[TBM_CC_POS +: 6]))
    else $error("charge scale not applied");
  a_cc_held: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE16
    !cc_written |=> $stable(fast_charge_current_setting))
    else $error("charge scale changed without write");

  // Temperature classification
  a_zone_fault: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2 RULE5
    (therm_monitor_on && cmp.above_hot) |=> zone == TBM_Z_FAULT)
    else $error("hot not reported as fault");
  a_zone_cold: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2
    (therm_monitor_on && cmp.below_cold) |=> zone == TBM_Z_FAULT)
    else $error("cold not reported as fault");
  a_zone_jeita: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2
    (therm_monitor_on && !cmp.above_hot && !cmp.below_cold
      && (cmp.above_warm || cmp.below_cool)) |=> zone == TBM_Z_JEITA)
    else $error("warm or cool not reported");
  a_zone_normal: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2
    (therm_monitor_on && cmp == 4'h0) |=> zone == TBM_Z_NORMAL)
    else $error("normal temperature not reported");
  a_zone_off: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2
    !therm_monitor_on |=> zone == TBM_Z_OFF)
    else $error("zone active with monitor off");
  a_zone_mux_free: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE5
    (sel_written && $stable(cmp) && $stable(therm_monitor_on)) |=> $stable(zone))
    else $error("select write moved the zone");

  // Register bus answers
  a_write_answer: assert property (@(posedge sys_clk) disable iff (!nrst)
    do_write |=> s_axi_bvalid)
    else $error("write not answered");
  a_wr_refused: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while response pending");
  a_unmapped_err: assert property (@(posedge sys_clk) disable iff (!nrst)
    (do_write && aw_addr == TBM_STAT_OFF) |=> (s_axi_bresp == 2'h2))
    else $error("status write not refused");
  a_bvalid_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");
  a_rvalid_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped");

  // Main scenarios
  c_null_then_dis: cover property (@(posedge sys_clk) disable iff (!nrst)
    mux_channel == TBM_CH_NULL ##[1:200] mux_channel == TBM_CH_DISCHG);
  c_charge_sel: cover property (@(posedge sys_clk) disable iff (!nrst)
    mux_channel == TBM_CH_CHG && switch_settled);
  c_thm_bias: cover property (@(posedge sys_clk) disable iff (!nrst)
    mux_channel == TBM_CH_THM && !charge_input_supply && therm_bias_on);
  c_jeita: cover property (@(posedge sys_clk) disable iff (!nrst)
    zone == TBM_Z_JEITA && monitor_buffer_on);
  c_cc_scaled: cover property (@(posedge sys_clk) disable iff (!nrst)
    mux_channel == TBM_CH_CHG && fast_charge_current_setting != 6'h00);
endmodule
`default_nettype wire

// *** testbench/tbm_adc_model.sv ***
// Purpose: External converter that samples the monitor pin on request
// Assumes: Converts only once the channel switching time has elapsed
// Notes: Pin high-Z shows as an inverted last sample, never a stale one
`default_nettype none
module tbm_adc_model
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic monitor_buffer_on,
  input wire logic switch_settled,
  input wire logic [3:0] mux_channel,
  output logic conv_done,
  output logic [3:0] conv_ch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  // Hold the request until the mux has settled, then take one sample
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy <= 1'b0;
      conv_done <= 1'b0;
      conv_ch <= 4'h0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (start)
        busy <= 1'b1;
      else if (busy && switch_settled)
      begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_ch <= monitor_buffer_on ? mux_channel : ~conv_ch;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tbm_top_tb.sv ***
// Purpose: Self-checking bench for thermistor bias and monitor mux control
// Assumes: Register map and bus timing of the block under test
// Notes: One task per scenario; watchdog ends a hang
`default_nettype none
module tbm_top_tb
  import tbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, nrst = 1'b0, charge_input_supply = 1'b0, start = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, mux_channel, dscale, conv_ch;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, bias_on, buf_on, settled, conv_done;
  logic [1:0] bresp, rresp, hot, warm, cool, cold;
  logic [5:0] cc;
  tbm_cmp_t cmp = '0;
  tbm_zone_t zone;
  int fail_count = 0, num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  tbm_top tbm_top_i (.sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .charge_input_supply(charge_input_supply), .cmp(cmp),
    .therm_bias_on(bias_on), .monitor_buffer_on(buf_on), .mux_channel(mux_channel),
    .hot_trip_level(hot), .warm_trip_level(warm), .cool_trip_level(cool),
    .cold_trip_level(cold), .discharge_monitor_fullscale(dscale),
    .fast_charge_current_setting(cc), .switch_settled(settled), .zone(zone));
  tbm_adc_model tbm_adc_model_i (.sys_clk(sys_clk), .nrst(nrst), .start(start),
    .monitor_buffer_on(buf_on), .switch_settled(settled), .mux_channel(mux_channel),
    .conv_done(conv_done), .conv_ch(conv_ch));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each channel released at the edge that takes it; local flags, not the pending NBAs
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge sys_clk);
      if (!aw_done && awready)
      begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready)
      begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!bvalid)
      @(posedge sys_clk);
    bready <= 1'b0;
    check(bresp, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge sys_clk);
    while (!arready);
    arvalid <= 1'b0;
    while (!rvalid)
      @(posedge sys_clk);
    rready <= 1'b0;
    check(rdata, ed);
    check(rresp, 2'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    rd(TBM_TRIP_OFF, 32'h0);
    rd(TBM_CTRL_OFF, 32'h0);
    rd(TBM_MUX_OFF, 32'h0);
    rd(TBM_STAT_OFF, 32'h101);
    wr(TBM_STAT_OFF, 32'hFF, 2'h2);
    rd(TBM_STAT_OFF, 32'h101);
    $display("reset test done");
  endtask
  task automatic t_trip();
    wr(TBM_TRIP_OFF, 32'hE4, 2'h0);
    check({hot, warm, cool, cold}, 8'h1B);
    rd(TBM_TRIP_OFF, 32'hE4);
    $display("trip test done");
  endtask
  // Table of supply, enable, select, expected bias, expected buffer
  task automatic t_bias();
    logic [7:0] tbl [6] = '{8'hC2, 8'h80, 8'h40, 8'h23, 8'h27, 8'h11};
    foreach (tbl[i])
    begin
      charge_input_supply <= tbl[i][7];
      wr(TBM_CTRL_OFF, {31'h0, tbl[i][6]}, 2'h0);
      wr(TBM_MUX_OFF, {28'h0, tbl[i][5:2]}, 2'h0);
      check({bias_on, buf_on}, tbl[i][1:0]);
      check(mux_channel, tbl[i][5:2]);
    end
    $display("bias test done");
  endtask
  // Host order: null, discharge, charge, then idle select
  task automatic t_current();
    logic [3:0] seq [3] = '{TBM_CH_NULL, TBM_CH_DISCHG, TBM_CH_CHG};
    int n;
    charge_input_supply <= 1'b0;
    foreach (seq[i])
    begin
      wr(TBM_MUX_OFF, {18'h0, 6'h2A, 4'h3, seq[i]}, 2'h0);
      check(settled, 1'b0);
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (!conv_done);
      check(conv_ch, seq[i]);
      check(n >= TBM_SW_CYC - 3 && n <= TBM_SW_CYC + 2, 1'b1);
      check({cc, dscale}, 10'h2A3);
    end
    wr(TBM_MUX_OFF, 32'h0, 2'h0);
    check(buf_on, 1'b0);
    $display("current test done");
  endtask
  task automatic t_zone();
    tbm_cmp_t c [4] = '{4'h0, 4'h4, 4'hC, 4'h1};
    tbm_zone_t z [4] = '{TBM_Z_NORMAL, TBM_Z_JEITA, TBM_Z_FAULT, TBM_Z_FAULT};
    wr(TBM_CTRL_OFF, 32'h1, 2'h0);
    wr(TBM_MUX_OFF, {28'h0, TBM_CH_THM}, 2'h0);
    foreach (c[i])
    begin
      cmp <= c[i];
      repeat (3) @(posedge sys_clk);
      check(zone, z[i]);
    end
    wr(TBM_CTRL_OFF, 32'h0, 2'h0);
    repeat (3) @(posedge sys_clk);
    check(zone, TBM_Z_OFF);
    $display("zone test done");
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_trip();
    t_bias();
    t_current();
    t_zone();
    conclude();
  end
  // Whole run is a few hundred cycles; this margin is far past it
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
